/* File: rtl/ato_core.sv */
// Contract
// - Prescaler read copies prescaler bits 7..4 into register B.
// - Prescaler read opcode decoded; one word, one cycle, carry kept, no skip.
// - Pointer read copies the three data pointer bits into accumulator bits 2..0.
// - Pointer read forces accumulator bit 3 to zero.
// - Pointer read opcode decoded; one word, one cycle, carry kept, no skip.
// - Interrupt control read opcode decoded; one word, one cycle, carry kept, no skip.
`timescale 1ns/10ps
`default_nettype none
module ato_core
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    input wire logic [7:0] timer_prescaler_count,
    input wire logic [2:0] data_pointer_reg,
    input wire logic [3:0] irq_ctrl_reg_one,
    input wire logic carry_in,
    output logic [3:0] acc_q,
    output logic [3:0] reg_b_q,
    output logic carry_flag_q,
    output logic skip_q,
    output logic done_q
);
    // Decode is purely combinational so each of the three opcodes retires in one cycle
    wire dec_pre;
    wire dec_ptr;
    wire dec_irq;
    wire dec_any;
    wire [3:0] pre_hi;
    wire [3:0] ptr_acc;
    wire [3:0] acc_d;
    wire [3:0] reg_b_d;
    wire carry_d;

    // Full ten-bit compare: neighbouring opcodes differ in as few as two bits
    assign dec_pre = instr_valid && (instr_word == ato_pkg::OPC_PRE_TO_B);
    assign dec_ptr = instr_valid && (instr_word == ato_pkg::OPC_PTR_TO_A);
    assign dec_irq = instr_valid && (instr_word == ato_pkg::OPC_IRQ_TO_A);
    assign dec_any = dec_pre || dec_ptr || dec_irq;

    // Only the upper nibble moves; the lower nibble of the count is never read
    assign pre_hi = timer_prescaler_count[ato_pkg::PRE_HI_LSB +: ato_pkg::NIB_W];
    // Bit 3 is forced low, not kept, so stale accumulator data cannot leak
    assign ptr_acc = {ato_pkg::CLEAR_BIT, data_pointer_reg};
    assign acc_d = dec_ptr ? ptr_acc : (dec_irq ? irq_ctrl_reg_one : acc_q);
    assign reg_b_d = dec_pre ? pre_hi : reg_b_q;

    // Carry only follows the rest of the core; these opcodes never touch it
    assign carry_d = dec_any ? carry_flag_q : carry_in;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            acc_q <= ato_pkg::NIB_ZERO;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            reg_b_q <= ato_pkg::NIB_ZERO;
        end
        else
        begin
            reg_b_q <= reg_b_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            carry_flag_q <= ato_pkg::CLEAR_BIT;
            skip_q <= ato_pkg::CLEAR_BIT;
            done_q <= ato_pkg::CLEAR_BIT;
        end
        else
        begin
            carry_flag_q <= carry_d;
            // None of these opcodes has a skip condition
            skip_q <= ato_pkg::CLEAR_BIT;
            done_q <= dec_any;
        end
    end

    // Checks look at registered outputs one cycle after the taking edge
    // Hold checks sample resetn themselves, so a reset release edge is never judged

    property p_pre;
        @(posedge sys_clk) disable iff (!resetn)
            dec_pre |=> done_q
            && reg_b_q == $past(timer_prescaler_count[ato_pkg::PRE_HI_LSB +: ato_pkg::NIB_W]);
    endproperty : p_pre
    a_pre: assert property (p_pre)
        else $error("prescaler read wrong");

    property p_pre_cy;
        @(posedge sys_clk) disable iff (!resetn)
            dec_pre |=> $stable(carry_flag_q) && !skip_q;
    endproperty : p_pre_cy
    a_pre_cy: assert property (p_pre_cy)
        else $error("prescaler read touched carry or skip");

    property p_ptr_lo;
        @(posedge sys_clk) disable iff (!resetn)
            dec_ptr |=> acc_q[ato_pkg::PTR_W-1:0] == $past(data_pointer_reg);
    endproperty : p_ptr_lo
    a_ptr_lo: assert property (p_ptr_lo)
        else $error("pointer bits wrong");

    property p_ptr_hi;
        @(posedge sys_clk) disable iff (!resetn)
            dec_ptr |=> acc_q[ato_pkg::ACC_MSB] == ato_pkg::CLEAR_BIT;
    endproperty : p_ptr_hi
    a_ptr_hi: assert property (p_ptr_hi)
        else $error("acc bit 3 not cleared");

    property p_ptr_cy;
        @(posedge sys_clk) disable iff (!resetn)
            dec_ptr |=> $stable(carry_flag_q) && !skip_q && done_q;
    endproperty : p_ptr_cy
    a_ptr_cy: assert property (p_ptr_cy)
        else $error("pointer read timing wrong");

    property p_irq_cy;
        @(posedge sys_clk) disable iff (!resetn)
            dec_irq |=> $stable(carry_flag_q) && !skip_q && done_q;
    endproperty : p_irq_cy
    a_irq_cy: assert property (p_irq_cy)
        else $error("irq read timing wrong");

    property p_irq;
        @(posedge sys_clk) disable iff (!resetn)
            dec_irq |=> acc_q == $past(irq_ctrl_reg_one);
    endproperty : p_irq
    a_irq: assert property (p_irq)
        else $error("irq read value wrong");

    // Register B may only move on the prescaler read
    property p_b_hold;
        @(posedge sys_clk) disable iff (!resetn)
            resetn && !dec_pre |=> $stable(reg_b_q);
    endproperty : p_b_hold
    a_b_hold: assert property (p_b_hold)
        else $error("register B changed");

    // The accumulator may only move on the two accumulator loads
    property p_acc_hold;
        @(posedge sys_clk) disable iff (!resetn)
            resetn && !(dec_ptr || dec_irq) |=> $stable(acc_q);
    endproperty : p_acc_hold
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulator changed");

    // Foreign opcodes leave carry to the rest of the core
    property p_carry_follow;
        @(posedge sys_clk) disable iff (!resetn)
            resetn && !dec_any |=> carry_flag_q == $past(carry_in);
    endproperty : p_carry_follow
    a_carry_follow: assert property (p_carry_follow)
        else $error("carry did not follow carry input");

    // Done is high for one cycle per taken opcode, silent for foreign opcodes
    property p_done_quiet;
        @(posedge sys_clk) disable iff (!resetn)
            resetn && !dec_any |=> !done_q;
    endproperty : p_done_quiet
    a_done_quiet: assert property (p_done_quiet)
        else $error("done raised without a taken opcode");

    // Not disabled by reset, since it judges the reset itself
    property p_reset_clear;
        @(posedge sys_clk)
            !resetn |=> acc_q == ato_pkg::NIB_ZERO && reg_b_q == ato_pkg::NIB_ZERO
            && !carry_flag_q && !skip_q && !done_q;
    endproperty : p_reset_clear
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");

    // Covers mark the scenarios the bench is expected to reach
    property p_cov_pre;
        @(posedge sys_clk) disable iff (!resetn)
            dec_pre;
    endproperty : p_cov_pre
    c_cov_pre: cover property (p_cov_pre);

    property p_cov_ptr_full;
        @(posedge sys_clk) disable iff (!resetn)
            dec_ptr && (&data_pointer_reg);
    endproperty : p_cov_ptr_full
    c_cov_ptr_full: cover property (p_cov_ptr_full);

    property p_cov_irq_ptr;
        @(posedge sys_clk) disable iff (!resetn)
            dec_irq ##1 dec_ptr;
    endproperty : p_cov_irq_ptr
    c_cov_irq_ptr: cover property (p_cov_irq_ptr);

    property p_cov_foreign;
        @(posedge sys_clk) disable iff (!resetn)
            instr_valid && !dec_any;
    endproperty : p_cov_foreign
    c_cov_foreign: cover property (p_cov_foreign);

    // First instruction on the first edge with reset released
    property p_cov_reset_first;
        @(posedge sys_clk)
            !resetn ##1 dec_any;
    endproperty : p_cov_reset_first
    c_cov_reset_first: cover property (p_cov_reset_first);
endmodule : ato_core
`default_nettype wire

/* File: rtl/ato_pkg.sv */
package ato_pkg;
    localparam int OPC_W = 10;
    localparam int NIB_W = 4;
    localparam int PTR_W = 3;
    localparam int PRE_W = 8;
    localparam logic [9:0] OPC_PRE_TO_B = 10'h275;
    localparam logic [9:0] OPC_PTR_TO_A = 10'h051;
    localparam logic [9:0] OPC_IRQ_TO_A = 10'h253;
    localparam int PRE_HI_LSB = 4;
    localparam int ACC_MSB = 3;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [2:0] PTR_ZERO = 3'h0;
    localparam logic [7:0] PRE_ZERO = 8'h00;
    localparam logic CLEAR_BIT = 1'h0;
    typedef enum logic [2:0]
    {
        ATO_IDLE = 3'b001,
        ATO_EXEC = 3'b010,
        ATO_HOLD = 3'b100
    } ato_state_e;
endpackage : ato_pkg

/* File: bench/ato_rom.sv */
`timescale 1ns/10ps
`default_nettype none
module ato_rom
(
    input wire logic [1:0] sel,
    output logic [9:0] word
);
    // Slot 3 holds a foreign opcode the core must ignore
    assign word = sel == 2'h0 ? ato_pkg::OPC_PRE_TO_B : sel == 2'h1 ? ato_pkg::OPC_PTR_TO_A :
        sel == 2'h2 ? ato_pkg::OPC_IRQ_TO_A : 10'h259;
endmodule : ato_rom
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic vld = 1'h0;
    logic cin = 1'h1;
    logic carry;
    logic sk;
    logic dn;
    logic [1:0] sel = 2'h0;
    logic [9:0] word;
    logic [7:0] pre_cnt = 8'h00;
    logic [2:0] dp = 3'h0;
    logic [3:0] irq_ctl = 4'h0;
    logic [3:0] acc;
    logic [3:0] rb;
    logic [3:0] status;
    int bad_count = 0;
    int checks_done = 0;
    // Status nibble: bit 2 carry, bit 1 skip, bit 0 done
    assign status = {1'h0, carry, sk, dn};
    ato_rom rom (.sel(sel), .word(word));
    ato_core dut
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .instr_valid(vld),
        .instr_word(word),
        .timer_prescaler_count(pre_cnt),
        .data_pointer_reg(dp),
        .irq_ctrl_reg_one(irq_ctl),
        .carry_in(cin),
        .acc_q(acc),
        .reg_b_q(rb),
        .carry_flag_q(carry),
        .skip_q(sk),
        .done_q(dn)
    );
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    task chk(input string n, input logic [3:0] e, input logic [3:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Carry_in drops while an opcode is taken, so a leaking carry shows up
    task test_irq_read;
        @(posedge sys_clk);
        vld <= 1'h1;
        sel <= 2'h2;
        irq_ctl <= 4'h9;
        cin <= 1'h0;
        @(posedge sys_clk);
        vld <= 1'h0;
        cin <= 1'h1;
        #1;
        chk("acc", 4'h9, acc);
        chk("reg_b", 4'h0, rb);
        chk("status", 4'h5, status);
        $display("test irq_read done");
    endtask : test_irq_read
    // Accumulator bit 3 is set beforehand, so the forced zero is visible
    task test_ptr_read;
        @(posedge sys_clk);
        vld <= 1'h1;
        sel <= 2'h1;
        dp <= 3'h6;
        irq_ctl <= 4'hF;
        cin <= 1'h0;
        @(posedge sys_clk);
        vld <= 1'h0;
        cin <= 1'h1;
        #1;
        chk("acc", 4'h6, acc);
        chk("reg_b", 4'h0, rb);
        chk("status", 4'h5, status);
        $display("test ptr_read done");
    endtask : test_ptr_read
    task test_pre_read;
        @(posedge sys_clk);
        vld <= 1'h1;
        sel <= 2'h0;
        pre_cnt <= 8'hC3;
        dp <= 3'h1;
        cin <= 1'h0;
        @(posedge sys_clk);
        vld <= 1'h0;
        cin <= 1'h1;
        #1;
        chk("reg_b", 4'hC, rb);
        chk("acc", 4'h6, acc);
        chk("status", 4'h5, status);
        $display("test pre_read done");
    endtask : test_pre_read
    // A neighbouring opcode must change nothing, and carry then follows carry_in
    task test_foreign;
        @(posedge sys_clk);
        vld <= 1'h1;
        sel <= 2'h3;
        pre_cnt <= 8'h5A;
        dp <= 3'h2;
        irq_ctl <= 4'h3;
        cin <= 1'h0;
        @(posedge sys_clk);
        vld <= 1'h0;
        cin <= 1'h1;
        #1;
        chk("acc", 4'h6, acc);
        chk("reg_b", 4'hC, rb);
        chk("status", 4'h0, status);
        $display("test foreign done");
    endtask : test_foreign
    task test_back_to_back;
        @(posedge sys_clk);
        vld <= 1'h1;
        sel <= 2'h2;
        irq_ctl <= 4'hE;
        dp <= 3'h7;
        cin <= 1'h0;
        @(posedge sys_clk);
        sel <= 2'h1;
        #1;
        chk("acc", 4'hE, acc);
        chk("status", 4'h5, status);
        @(posedge sys_clk);
        vld <= 1'h0;
        cin <= 1'h1;
        #1;
        chk("acc", 4'h7, acc);
        chk("reg_b", 4'hC, rb);
        chk("status", 4'h5, status);
        @(posedge sys_clk);
        #1;
        chk("status", 4'h4, status);
        $display("test back_to_back done");
    endtask : test_back_to_back
    // First instruction lands on the first edge with reset released
    task test_mid_reset;
        @(posedge sys_clk);
        resetn <= 1'h0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        resetn <= 1'h1;
        vld <= 1'h1;
        sel <= 2'h1;
        dp <= 3'h3;
        #1;
        chk("acc", 4'h0, acc);
        chk("reg_b", 4'h0, rb);
        chk("status", 4'h0, status);
        @(posedge sys_clk);
        vld <= 1'h0;
        #1;
        chk("acc", 4'h3, acc);
        chk("status", 4'h1, status);
        @(posedge sys_clk);
        #1;
        chk("acc", 4'h3, acc);
        chk("status", 4'h4, status);
        $display("test mid_reset done");
    endtask : test_mid_reset
    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'h1;
        test_irq_read();
        test_ptr_read();
        test_pre_read();
        test_foreign();
        test_back_to_back();
        test_mid_reset();
        results();
    end
    // The scenarios need under 40 cycles; 200 cycles only runs out on a hang
    initial
    begin
        repeat (200) @(posedge sys_clk);
        bad_count++;
        results();
    end
endmodule : tb_top
`default_nettype wire
